// ### core/cfpm_pkg.sv
// Shared constants and types for the core fetch pipeline and memory map
package cfpm_pkg;
  localparam int PC_W = 13;
  localparam int PROG_A_W = 12;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PHASES_PER_CYCLE = 4;
  localparam logic [12:0] PC_RESET_VEC = 13'h0000;
  localparam logic [12:0] PC_INT_VEC = 13'h0004;
  localparam logic [12:0] PC_ONE = 13'h0001;

  // Data memory offsets within a bank
  localparam logic [6:0] OFF_INDIRECT = 7'h00;
  localparam logic [6:0] OFF_PCL = 7'h02;
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_FSR = 7'h04;
  localparam logic [6:0] OFF_PROGRAM_COUNTER_HIGH_LATCH = 7'h0A;
  localparam logic [6:0] OFF_INTERRUPT_CONTROL = 7'h0B;
  localparam logic [6:0] OFF_GPR_BASE = 7'h20;
  localparam int GPR_DEPTH = 96;
  localparam int GPR_IDX_W = 7;

  // Status fields and reset values
  localparam int ST_IRP = 7;
  localparam int ST_RP1 = 6;
  localparam int ST_RP0 = 5;
  localparam int ST_Z = 2;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] STATUS_WR_MASK = 8'hE7;
  localparam logic [4:0] PROGRAM_COUNTER_HIGH_LATCH_RST = 5'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_RST = 8'h00;
  localparam logic [7:0] FSR_RST = 8'h00;
  localparam int INTERRUPT_CONTROL_GIE = 7;

  // Avalon register byte addresses
  localparam logic [7:0] AV_CTRL = 8'h00;
  localparam logic [7:0] AV_PC = 8'h04;
  localparam logic [7:0] AV_ILATCH = 8'h08;
  localparam logic [7:0] AV_WREG = 8'h0C;
  localparam logic [7:0] AV_STATUS = 8'h10;
  localparam logic [7:0] AV_MADDR = 8'h14;
  localparam logic [7:0] AV_MDATA = 8'h18;
  localparam logic [7:0] AV_STATE = 8'h1C;
  localparam int CTRL_RUN = 0;
  localparam logic CTRL_RUN_RST = 1'b1;

  // Instruction encodings
  localparam logic [2:0] OPC_JUMP = 3'b101;
  localparam logic [3:0] OPC_MOVLW = 4'b1100;
  localparam logic [1:0] OPC_BYTE = 2'b00;
  localparam logic [3:0] BOP_MOVWF = 4'h0;
  localparam logic [3:0] BOP_CLR = 4'h1;
  localparam logic [3:0] BOP_DEC = 4'h3;
  localparam logic [3:0] BOP_ADD = 4'h7;
  localparam logic [3:0] BOP_MOV = 4'h8;
  localparam logic [3:0] BOP_INC = 4'hA;

  typedef enum logic [3:0] {
    CFPM_PH1 = 4'b0001,
    CFPM_PH2 = 4'b0010,
    CFPM_PH3 = 4'b0100,
    CFPM_PH4 = 4'b1000
  } cfpm_phase_e;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } cfpm_dmw_s;
endpackage : cfpm_pkg

// ### core/cfpm_phase_gen.sv
// Divide-by-four quadrature phase generator
`timescale 1ns/1ps
module cfpm_phase_gen
  import cfpm_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic run, // Advance phases when high
  output cfpm_phase_e phase // One-hot current phase
);
  cfpm_phase_e phase_nxt;

  always_comb begin
    case (phase)
      CFPM_PH1: phase_nxt = CFPM_PH2;
      CFPM_PH2: phase_nxt = CFPM_PH3;
      CFPM_PH3: phase_nxt = CFPM_PH4;
      CFPM_PH4: phase_nxt = CFPM_PH1;
      default: phase_nxt = CFPM_PH1;
    endcase
  end

  // Phases never overlap: exactly one bit is set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= CFPM_PH1;
    end else if (run) begin
      phase <= phase_nxt;
    end
  end
endmodule : cfpm_phase_gen

// ### core/cfpm_gpr_bank.sv
// One bank of general register storage with two read ports
`timescale 1ns/1ps
module cfpm_gpr_bank
  import cfpm_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic we, // Write strobe
  input wire logic [6:0] widx, // Write index
  input wire logic [7:0] wdata, // Write data
  input wire logic [6:0] ridx_a, // Core read index
  input wire logic [6:0] ridx_b, // Debug read index
  output logic [7:0] rdata_a, // Core read data
  output logic [7:0] rdata_b // Debug read data
);
  logic [7:0] mem_r [GPR_DEPTH];

  assign rdata_a = (int'(ridx_a) < GPR_DEPTH) ? mem_r[ridx_a] : 8'h00;
  assign rdata_b = (int'(ridx_b) < GPR_DEPTH) ? mem_r[ridx_b] : 8'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < GPR_DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (we && int'(widx) < GPR_DEPTH) begin
      mem_r[widx] <= wdata;
    end
  end
endmodule : cfpm_gpr_bank

// ### core/cfpm_core.sv
// Core sequencer: phase timing, fetch/execute pipeline, banked data memory
//
// Summary of operation
// - Oscillator divided by four into four non-overlapping phases per cycle.
// - Program counter increments in phase one, starting each fetch.
// - Fetched program word is latched in phase four.
// - A fetched instruction executes during the following instruction cycle.
// - Fetch of the next overlaps execution, one instruction per cycle.
// - A program counter change flushes the fetched word; branch takes two cycles.
// - Operand read in phase two, destination written in phase four.
// - Program counter is 13 bits wide, an 8K word space.
// - Program space is 0000h-0FFFh; higher addresses wrap around.
// - Reset starts at 0000h; interrupt vectors to 0004h.
// - Status bit 5 selects one of two data banks; bit 6 is not decoded.
// - Banks are 128 bytes; special registers low, general RAM from 20h.
// - Core special registers are mirrored so both banks reach one register.
// - Register file reachable directly or through the pointer register.
// - Offsets 00h/80h have no storage; they act on the pointed location.
// - Indirect access uses the eight pointer bits as data address.
`timescale 1ns/1ps
module cfpm_core
  import cfpm_pkg::*;
(
  input wire logic clk, // 10 MHz oscillator input
  input wire logic rst_b, // Async reset, active low
  input wire logic [13:0] prog_data, // Program memory word at prog_addr
  input wire logic int_req, // Interrupt request level
  output logic [11:0] prog_addr, // Program memory address
  output cfpm_phase_e quad_phase, // Current quadrature phase
  input wire logic [7:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest // Avalon wait request
);
  logic run_r;
  logic [12:0] pc_r;
  logic [11:0] prog_addr_r;
  logic [13:0] fetch_latch_r;
  logic fetch_valid_r;
  logic [13:0] ilatch_r;
  logic exec_valid_r;
  logic flush_r;
  logic [7:0] opnd_r;
  logic [7:0] res_r;
  logic res_ok_r;
  logic [7:0] wreg_r;
  logic [7:0] status_r;
  logic [7:0] fsr_r;
  logic [4:0] program_counter_high_latch_r;
  logic [7:0] interrupt_control_r;
  logic [7:0] dbg_addr_r;
  logic [31:0] rdata_r;
  logic wait_r;

  // Phase strobes
  logic ph1, ph2, ph3, ph4;
  assign ph1 = run_r && (quad_phase == CFPM_PH1);
  assign ph2 = run_r && (quad_phase == CFPM_PH2);
  assign ph3 = run_r && (quad_phase == CFPM_PH3);
  assign ph4 = run_r && (quad_phase == CFPM_PH4);

  cfpm_phase_gen u_phase (
    .clk(clk),
    .rst_b(rst_b),
    .run(run_r),
    .phase(quad_phase)
  );

  // Instruction decode
  logic is_jump, is_movlw, is_byte, dbit, ind_sel;
  logic [3:0] bop;
  logic [6:0] freg;
  assign is_jump = ilatch_r[13:11] == OPC_JUMP;
  assign is_movlw = ilatch_r[13:10] == OPC_MOVLW;
  assign is_byte = ilatch_r[13:12] == OPC_BYTE;
  assign bop = ilatch_r[11:8];
  assign dbit = ilatch_r[7];
  assign freg = ilatch_r[6:0];
  assign ind_sel = freg == OFF_INDIRECT;

  // Only two banks exist, so the upper bank bit is not decoded
  logic [7:0] dir_addr, eff_addr;
  assign dir_addr = {status_r[ST_RP0], freg};
  assign eff_addr = ind_sel ? fsr_r : dir_addr;

  // General register storage: one instance per implemented bank
  cfpm_dmw_s dmw;
  logic [7:0] g_rd_a [2];
  logic [7:0] g_rd_b [2];
  logic [6:0] core_idx, dbg_idx, w_idx;
  assign core_idx = eff_addr[6:0] - OFF_GPR_BASE;
  assign dbg_idx = dbg_addr_r[6:0] - OFF_GPR_BASE;
  assign w_idx = dmw.addr[6:0] - OFF_GPR_BASE;

  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic bank_we;
    assign bank_we = dmw.we && (dmw.addr[7] == b[0]) && (dmw.addr[6:0] >= OFF_GPR_BASE);
    cfpm_gpr_bank u_gpr (
      .clk(clk),
      .rst_b(rst_b),
      .we(bank_we),
      .widx(w_idx),
      .wdata(dmw.data),
      .ridx_a(core_idx),
      .ridx_b(dbg_idx),
      .rdata_a(g_rd_a[b]),
      .rdata_b(g_rd_b[b])
    );
  end

  // Address map read; core registers decode on offset only, so they mirror
  function automatic logic [7:0] map_rd(input logic [7:0] a, input logic [7:0] g);
    logic [7:0] v;
    v = 8'h00;
    if (a[6:0] >= OFF_GPR_BASE) begin
      v = g;
    end else begin
      case (a[6:0])
        OFF_PCL: v = pc_r[7:0];
        OFF_STATUS: v = status_r;
        OFF_FSR: v = fsr_r;
        OFF_PROGRAM_COUNTER_HIGH_LATCH: v = {3'h0, program_counter_high_latch_r};
        OFF_INTERRUPT_CONTROL: v = interrupt_control_r;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction : map_rd

  // A pointer that names the indirect location itself reads zero
  // Kept in a process so that register changes seen inside map_rd also re-evaluate
  logic [7:0] core_rd, dbg_rd;
  always_comb begin
    core_rd = map_rd(eff_addr, g_rd_a[eff_addr[7]]);
    if (eff_addr[6:0] == OFF_INDIRECT) begin
      core_rd = 8'h00;
    end
    dbg_rd = map_rd(dbg_addr_r, g_rd_b[dbg_addr_r[7]]);
  end

  // Execution datapath
  logic [7:0] alu_res;
  logic alu_ok;
  always_comb begin
    alu_res = opnd_r;
    alu_ok = 1'b1;
    case (bop)
      BOP_MOVWF: begin
        alu_res = wreg_r;
        alu_ok = dbit;
      end
      BOP_CLR: alu_res = 8'h00;
      BOP_DEC: alu_res = opnd_r - 8'h01;
      BOP_ADD: alu_res = opnd_r + wreg_r;
      BOP_MOV: alu_res = opnd_r;
      BOP_INC: alu_res = opnd_r + 8'h01;
      default: alu_ok = 1'b0;
    endcase
  end

  logic wr_f, wr_w, z_upd, pcl_wr, jump_go, int_go, redirect;
  assign wr_f = ph4 && exec_valid_r && is_byte && res_ok_r && dbit;
  assign wr_w = ph4 && exec_valid_r && (is_movlw || (is_byte && res_ok_r && !dbit));
  assign z_upd = ph4 && exec_valid_r && is_byte && res_ok_r && (bop != BOP_MOVWF);
  assign pcl_wr = wr_f && (eff_addr[6:0] == OFF_PCL);
  assign jump_go = ph4 && exec_valid_r && is_jump;
  assign int_go = ph4 && !flush_r && !jump_go && !pcl_wr && int_req && interrupt_control_r[INTERRUPT_CONTROL_GIE];
  assign redirect = jump_go || pcl_wr || int_go;

  assign dmw.we = wr_f && (eff_addr[6:0] != OFF_INDIRECT);
  assign dmw.addr = eff_addr;
  assign dmw.data = res_r;

  logic [12:0] pc_nxt;
  always_comb begin
    pc_nxt = pc_r;
    if (jump_go) begin
      pc_nxt = {program_counter_high_latch_r[4:3], ilatch_r[10:0]};
    end else if (pcl_wr) begin
      pc_nxt = {program_counter_high_latch_r, res_r};
    end else if (int_go) begin
      pc_nxt = PC_INT_VEC;
    end else if (ph1) begin
      pc_nxt = pc_r + PC_ONE;
    end
  end

  // Program counter and fetch stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= PC_RESET_VEC;
      prog_addr_r <= 12'h000;
      fetch_latch_r <= 14'h0000;
      fetch_valid_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      if (ph1) begin
        prog_addr_r <= pc_r[11:0];
      end
      if (ph4) begin
        fetch_latch_r <= prog_data;
        fetch_valid_r <= 1'b1;
      end
    end
  end
  assign prog_addr = prog_addr_r;

  // Execute stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ilatch_r <= 14'h0000;
      exec_valid_r <= 1'b0;
      flush_r <= 1'b0;
      opnd_r <= 8'h00;
      res_r <= 8'h00;
      res_ok_r <= 1'b0;
    end else begin
      if (ph1) begin
        ilatch_r <= fetch_latch_r;
        exec_valid_r <= fetch_valid_r && !flush_r;
        flush_r <= 1'b0;
      end
      if (ph2) begin
        opnd_r <= core_rd;
      end
      if (ph3) begin
        res_r <= alu_res;
        res_ok_r <= alu_ok;
      end
      if (redirect) begin
        flush_r <= 1'b1;
      end
    end
  end

  // Core special registers written in phase four
  logic f_status, f_fsr, f_program_counter_high_latch, f_interrupt_control;
  assign f_status = dmw.we && (eff_addr[6:0] == OFF_STATUS);
  assign f_fsr = dmw.we && (eff_addr[6:0] == OFF_FSR);
  assign f_program_counter_high_latch = dmw.we && (eff_addr[6:0] == OFF_PROGRAM_COUNTER_HIGH_LATCH);
  assign f_interrupt_control = dmw.we && (eff_addr[6:0] == OFF_INTERRUPT_CONTROL);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wreg_r <= 8'h00;
      status_r <= STATUS_RST;
      fsr_r <= FSR_RST;
      program_counter_high_latch_r <= PROGRAM_COUNTER_HIGH_LATCH_RST;
      interrupt_control_r <= INTERRUPT_CONTROL_RST;
    end else begin
      if (wr_w) begin
        wreg_r <= is_movlw ? ilatch_r[7:0] : res_r;
      end
      if (f_status) begin
        status_r <= (res_r & STATUS_WR_MASK) | (status_r & ~STATUS_WR_MASK);
      end else if (z_upd) begin
        status_r[ST_Z] <= (res_r == 8'h00);
      end
      if (f_fsr) begin
        fsr_r <= res_r;
      end
      if (f_program_counter_high_latch) begin
        program_counter_high_latch_r <= res_r[4:0];
      end
      if (f_interrupt_control) begin
        interrupt_control_r <= res_r;
      end else if (int_go) begin
        interrupt_control_r[INTERRUPT_CONTROL_GIE] <= 1'b0;
      end
    end
  end

  // Avalon slave: one wait state, answer on the edge after request
  logic req, take;
  assign req = avs_read || avs_write;
  assign take = req && !wait_r;

  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      AV_CTRL: rd_mux = {31'h0, run_r};
      AV_PC: rd_mux = {19'h0, pc_r};
      AV_ILATCH: rd_mux = {18'h0, ilatch_r};
      AV_WREG: rd_mux = {24'h0, wreg_r};
      AV_STATUS: rd_mux = {24'h0, status_r};
      AV_MADDR: rd_mux = {24'h0, dbg_addr_r};
      AV_MDATA: rd_mux = {24'h0, dbg_rd};
      AV_STATE: rd_mux = {26'h0, exec_valid_r, flush_r, quad_phase};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      run_r <= CTRL_RUN_RST;
      dbg_addr_r <= 8'h00;
    end else begin
      wait_r <= !(req && wait_r);
      if (avs_read && wait_r) begin
        rdata_r <= rd_mux;
      end
      if (take && avs_write && avs_address == AV_CTRL) begin
        run_r <= avs_writedata[CTRL_RUN];
      end
      if (take && avs_write && avs_address == AV_MADDR) begin
        dbg_addr_r <= avs_writedata[7:0];
      end
    end
  end
  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
endmodule : cfpm_core

// ### verif/cfpm_core_chk.sv
// Timing checker for the core sequencer ports
`timescale 1ns/1ps
module cfpm_core_chk
  import cfpm_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic [13:0] prog_data, // Program word
  input wire logic int_req, // Interrupt request
  input wire logic [11:0] prog_addr, // Program address
  input wire cfpm_phase_e quad_phase, // Phase
  input wire logic [7:0] avs_address, // Bus address
  input wire logic avs_read, // Bus read
  input wire logic avs_write, // Bus write
  input wire logic [31:0] avs_writedata, // Bus write data
  input wire logic [31:0] avs_readdata, // Bus read data
  input wire logic avs_waitrequest // Bus wait
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_PH_HOT: assert property (
    $onehot(quad_phase)) else $error("phase not one-hot");
  AST_PH_ROT: assert property (
    $changed(quad_phase) |->
      quad_phase == {$past(quad_phase[2:0]), $past(quad_phase[3])})
    else $error("phase out of order");
  AST_PA_HOLD: assert property (
    $changed(prog_addr) |=> $stable(prog_addr) [*3]) else $error("address held short");
  AST_PA_PH: assert property (
    $changed(prog_addr) |-> $changed(quad_phase)) else $error("address moved mid-phase");
  AST_RST_VEC: assert property (
    $rose(rst_b) |-> prog_addr == PC_RESET_VEC[11:0]) else $error("bad start address");
  AST_PC_W: assert property (
    avs_read && !avs_waitrequest && avs_address == AV_PC |-> avs_readdata[31:13] == '0)
    else $error("counter wider than 13 bits");
  AST_UNMAP: assert property (
    avs_read && !avs_waitrequest && avs_address > AV_STATE |-> avs_readdata == '0)
    else $error("unmapped read not zero");
  AST_WAIT_ANS: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  AST_WAIT_PULSE: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
endmodule : cfpm_core_chk

bind cfpm_core cfpm_core_chk u_chk (.clk(clk), .rst_b(rst_b), .prog_data(prog_data),
  .int_req(int_req), .prog_addr(prog_addr), .quad_phase(quad_phase),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest));

// ### verif/cfpm_core_bench.sv
// Self-checking bench for the core sequencer
`timescale 1ns/1ps
module cfpm_core_bench import cfpm_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] prog_data = 14'h0000;
  logic int_req = 1'b0;
  logic [11:0] prog_addr;
  cfpm_phase_e quad_phase;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [13:0] prog [0:4095];
  logic [31:0] rd;
  int n_mismatch = 0;
  int total_checks = 0;
  int n;

  always #50 clk = ~clk;
  // Registered lookup is enough: the word is needed three clocks later
  always @(posedge clk) prog_data <= prog[prog_addr];

  cfpm_core DUT (.clk(clk), .rst_b(rst_b), .prog_data(prog_data), .int_req(int_req),
    .prog_addr(prog_addr), .quad_phase(quad_phase), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task av(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    chk(k < 50, 1);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : av

  task mem(input logic [7:0] a, input logic [7:0] e);
    av(1'b1, AV_MADDR, {24'h0, a});
    av(1'b0, AV_MDATA, 32'h0);
    chk(rd, {24'h0, e});
  endtask : mem

  task wait_pa(input logic [11:0] a);
    n = 0;
    while (prog_addr !== a && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_pa

  task wipe;
    foreach (prog[i]) prog[i] = 14'h0000;
  endtask : wipe

  task restart;
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    chk(prog_addr, 32'h0);
    chk(quad_phase, CFPM_PH1);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask : restart

  task t_regs;
    restart();
    av(1'b0, AV_CTRL, 32'h0);
    chk(rd, 32'h1);
    av(1'b1, AV_STATUS, 32'hFF);
    av(1'b0, AV_STATUS, 32'h0);
    chk(rd, {24'h0, STATUS_RST});
    av(1'b1, 8'h40, 32'h5A);
    av(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    mem(8'h01, 8'h00);
    mem(8'h80, 8'h00);
  endtask : t_regs

  task t_pipe;
    logic [13:0] pb [13];
    // Banks zero and one only, upper bank bits stay clear; 12 must be flushed
    pb = '{14'h3055, 14'h00A0, 14'h3020, 14'h0084, 14'h0A80, 14'h3020, 14'h0083,
      14'h3077, 14'h00A0, 14'h3008, 14'h008A, 14'h2FFF, 14'h3099};
    wipe();
    foreach (pb[i]) prog[i] = pb[i];
    restart();
    wait_pa(12'h00B);
    wait_pa(12'hFFF);
    chk(n, 8);
    wait_pa(12'h000);
    chk(n, 4);
    av(1'b0, AV_WREG, 32'h0);
    chk(rd, 32'h08);
    av(1'b1, AV_CTRL, 32'h0);
    mem(8'h20, 8'h56);
    mem(8'hA0, 8'h77);
    mem(8'h04, 8'h20);
    mem(8'h84, 8'h20);
    mem(8'h8A, 8'h08);
    mem(8'h83, 8'h38);
    mem(8'h00, 8'h00);
  endtask : t_pipe

  task t_irq;
    wipe();
    prog[0] = 14'h3080;
    prog[1] = 14'h008B;
    prog[2] = 14'h2810;
    prog[4] = 14'h2810;
    prog[16] = 14'h2810;
    restart();
    wait_pa(12'h010);
    repeat (12) @(posedge clk);
    int_req <= 1'b1;
    wait_pa(12'h004);
    chk(n < 16, 1);
    wait_pa(12'h010);
    // Vector cleared the enable, so a held request must not re-enter
    wait_pa(12'h004);
    chk(n, 400);
    int_req <= 1'b0;
  endtask : t_irq

  initial begin
    wipe();
    @(posedge clk);
    t_regs();
    t_pipe();
    t_irq();
    summarize();
  end

  // Whole run needs under 2000 clocks
  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end
endmodule : cfpm_core_bench
